// *** design/setws_dev.sv ***
// setws_dev: memory end of the two-wire link, 1024 bytes with page writes.
// assumes the link lines come from outside this clock domain.
//
// Summary of operation
// [RULE_01] start: data falls while clock is high
// [RULE_02] ignore the bus until a start
// [RULE_03] stop: data rises while clock is high
// [RULE_04] stop after a read enters standby
// [RULE_05] data changes only while clock is low
// [RULE_06] receiver pulls data low on ninth clock
// [RULE_07] acknowledge only a matching slave address
// [RULE_08] acknowledge every byte once selected for write
// [RULE_09] read: send byte, continue only on acknowledge
// [RULE_10] master stops after an unacknowledged read byte
// [RULE_11] fifth address bit matches the select pin
// [RULE_12] two address bits extend the word address
// [RULE_13] last address bit: one read, zero write
// [RULE_14] byte write: program array at stop
// [RULE_15] ignore the bus during the write cycle
// [RULE_16] page write takes up to sixteen bytes
// [RULE_17] write increments low four bits, page wraps
// [RULE_18] no acknowledge while busy; poll until given
// [RULE_19] master ends read by stop or no acknowledge
// [RULE_20] counter holds last accessed address plus one
// [RULE_21] read address sends byte at the counter
// [RULE_22] random read: dummy write then repeated start
// [RULE_23] reads increment all bits, wrapping to zero
// [RULE_24] mismatch: stay released until next start
`timescale 1ns/1ps
`default_nettype none
`include "setws_defs.svh"
module setws_dev #(
  parameter int         WRITE_CYCLES = `SETWS_WRITE_CYC,
  parameter logic [3:0] TYPE_ID      = `SETWS_TYPE_ID
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  input  wire logic                  device_select_pin_i,
  setws_link_if.dev                  link,
  output logic                       busy_o,
  output logic                       standby_o,
  output var setws_pkg::setws_byte_t rx_byte_o
);
  import setws_pkg::*;
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int PW = `SETWS_PAGE_W;
  localparam int AW = `SETWS_ADDR_W;

  setws_dst_t  st_ff;
  setws_kind_t kind_ff;
  logic [2:0]  scl_sy_ff;
  logic [2:0]  sda_sy_ff;
  logic [1:0]  sel_sy_ff;
  logic [3:0]  bit_ff;
  setws_byte_t sh_ff;
  setws_byte_t tx_ff;
  logic        ack_ff;
  logic        rd_ff;
  logic        more_ff;
  logic        busy_ff;
  logic        standby_ff;
  logic [AW-1:0]      cnt_ff;
  logic [(1<<PW)-1:0] mask_ff;
  logic [TW-1:0]      tmr_ff;
  setws_byte_t mem  [1 << AW];
  setws_byte_t pbuf [1 << PW];

  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        live;
  logic        rx_bit;
  logic        byte_done;
  logic        tx_shift;
  logic        rack_bit;
  logic        load_tx;
  logic        addr_hit;
  logic        commit;
  setws_byte_t rx_byte;

  // ==========================================================
  // line sampling and condition detection
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
      sel_sy_ff <= 2'h0;
    end else if (ce_i) begin
      scl_sy_ff <= {scl_sy_ff[1:0], link.scl};
      sda_sy_ff <= {sda_sy_ff[1:0], link.sda};
      sel_sy_ff <= {sel_sy_ff[0], device_select_pin_i};
    end
  end

  assign scl_rise = scl_sy_ff[1] & ~scl_sy_ff[2];
  assign scl_fall = ~scl_sy_ff[1] & scl_sy_ff[2];
  // inputs stay dead while programming, so polling sees no acknowledge
  assign start_ev = scl_sy_ff[1] & scl_sy_ff[2] & sda_sy_ff[2] & ~sda_sy_ff[1]
                    & ~busy_ff; // see [RULE_01] [RULE_15] [RULE_18]
  assign stop_ev  = scl_sy_ff[1] & scl_sy_ff[2] & ~sda_sy_ff[2] & sda_sy_ff[1]
                    & ~busy_ff; // see [RULE_03]

  assign live      = ~busy_ff & ~start_ev & ~stop_ev;
  assign rx_byte   = {sh_ff[6:0], sda_sy_ff[1]};
  assign rx_bit    = live & scl_rise & (st_ff == D_RX) & (bit_ff != 4'h8);
  assign byte_done = rx_bit & (bit_ff == 4'h7);
  assign tx_shift  = live & scl_fall & (st_ff == D_TX) & (bit_ff != 4'h8);
  assign rack_bit  = live & scl_rise & (st_ff == D_RACK);
  assign load_tx   = live & scl_fall & (((st_ff == D_ACK) & rd_ff)
                                        | ((st_ff == D_RACK) & more_ff));
  assign addr_hit  = setws_slave_addr(TYPE_ID, sel_sy_ff[1], rx_byte[2:1], rx_byte[0])
                     == rx_byte; // see [RULE_07] [RULE_11]
  assign commit    = busy_ff & (tmr_ff == TW'(WRITE_CYCLES - 1));

  // released except for our acknowledge and zero data bits
  assign link.dev_sda_oe  = (st_ff == D_ACK) | ((st_ff == D_TX) & ~tx_ff[7]); // see [RULE_06]
  assign link.dev_sda_out = 1'b0;
  assign busy_o           = busy_ff;
  assign standby_o        = standby_ff & ~busy_ff;
  assign rx_byte_o        = sh_ff;

  // ==========================================================
  // protocol state
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff  <= D_IDLE;
      bit_ff <= 4'h0;
    end else if (ce_i) begin
      if (busy_ff) begin
        st_ff <= D_IDLE; // see [RULE_15]
      end else if (start_ev) begin
        st_ff  <= D_RX; // see [RULE_02]
        bit_ff <= 4'h0;
      end else if (stop_ev) begin
        st_ff <= D_IDLE;
      end else begin
        case (st_ff)
          D_RX: begin
            if (scl_rise) bit_ff <= bit_ff + 4'h1;
            else if (scl_fall && bit_ff == 4'h8) st_ff <= ack_ff ? D_ACK : D_IDLE; // see [RULE_24]
          end
          D_ACK: begin
            if (scl_fall) begin
              bit_ff <= 4'h0;
              st_ff  <= rd_ff ? D_TX : D_RX; // see [RULE_13]
            end
          end
          D_TX: begin
            if (scl_rise) bit_ff <= bit_ff + 4'h1;
            else if (scl_fall && bit_ff == 4'h8) st_ff <= D_RACK; // see [RULE_05]
          end
          D_RACK: begin
            if (scl_fall) begin
              bit_ff <= 4'h0;
              st_ff  <= more_ff ? D_TX : D_IDLE; // see [RULE_09]
            end
          end
          D_IDLE: begin
          end
          default: st_ff <= D_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // byte handling and address counter
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kind_ff <= K_SLAVE;
      sh_ff   <= 8'h00;
      tx_ff   <= 8'h00;
      ack_ff  <= 1'b0;
      rd_ff   <= 1'b0;
      more_ff <= 1'b0;
      cnt_ff  <= '0;
      mask_ff <= '0;
    end else if (ce_i) begin
      if (start_ev) begin
        // bytes of an unfinished write are dropped by a repeated start
        kind_ff <= K_SLAVE;
        ack_ff  <= 1'b0;
        mask_ff <= '0;
      end else if (rx_bit) begin
        sh_ff <= rx_byte;
        if (byte_done) begin
          case (kind_ff)
            K_SLAVE: begin
              ack_ff  <= addr_hit; // see [RULE_07]
              rd_ff   <= rx_byte[0]; // see [RULE_21]
              kind_ff <= K_WORD;
              if (addr_hit) cnt_ff[AW-1:8] <= rx_byte[2:1]; // see [RULE_12]
            end
            K_WORD: begin
              ack_ff  <= 1'b1; // see [RULE_08] [RULE_22]
              cnt_ff[7:0] <= rx_byte;
              kind_ff <= K_DATA;
            end
            K_DATA: begin
              ack_ff  <= 1'b1; // see [RULE_16]
              mask_ff[cnt_ff[PW-1:0]] <= 1'b1;
              cnt_ff[PW-1:0] <= cnt_ff[PW-1:0] + 4'h1; // see [RULE_17] [RULE_20]
            end
            default: kind_ff <= K_SLAVE;
          endcase
        end
      end else if (load_tx) begin
        tx_ff  <= mem[cnt_ff]; // see [RULE_21]
        cnt_ff <= cnt_ff + 10'h001; // see [RULE_20] [RULE_23]
      end else if (tx_shift) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end else if (rack_bit) begin
        more_ff <= ~sda_sy_ff[1]; // see [RULE_09]
      end
      if (commit) mask_ff <= '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (ce_i && byte_done && kind_ff == K_DATA) pbuf[cnt_ff[PW-1:0]] <= rx_byte;
  end

  // ==========================================================
  // self-timed write cycle; the page is programmed in one go at its end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_ff    <= 1'b0;
      tmr_ff     <= '0;
      standby_ff <= 1'b1;
    end else if (ce_i) begin
      if (stop_ev && mask_ff != '0) begin
        busy_ff <= 1'b1; // see [RULE_14]
        tmr_ff  <= '0;
      end else if (commit) begin
        busy_ff <= 1'b0; // see [RULE_18]
      end else if (busy_ff) begin
        tmr_ff <= tmr_ff + 1'b1;
      end
      if (start_ev) standby_ff <= 1'b0;
      else if (stop_ev) standby_ff <= 1'b1; // see [RULE_04]
    end
  end

  always_ff @(posedge clock_i) begin
    if (ce_i && commit) begin
      for (int i = 0; i < (1 << PW); i++) begin
        if (mask_ff[i]) mem[{cnt_ff[AW-1:PW], PW'(i)}] <= pbuf[i]; // see [RULE_14] [RULE_17]
      end
    end
  end
endmodule : setws_dev
`default_nettype wire

// *** design/setws_defs.svh ***
// setws_defs.svh: constants shared by both ends of the two-wire memory link.
// assumes both ends run from the same 40 MHz core clock.
`ifndef SETWS_DEFS_SVH
`define SETWS_DEFS_SVH
`define SETWS_CLK_NS      25
`define SETWS_WRITE_MS    5
`define SETWS_WRITE_CYC   ((`SETWS_WRITE_MS * 1000000) / `SETWS_CLK_NS)
`define SETWS_SCL_HALF_NS 5000
`define SETWS_SCL_QTR_CYC ((`SETWS_SCL_HALF_NS / 2 + `SETWS_CLK_NS - 1) / `SETWS_CLK_NS)
// arbitrary value
`define SETWS_TYPE_ID     4'h6
`define SETWS_ADDR_W      10
`define SETWS_PAGE_W      4
`define SETWS_FIFO_DEPTH  8
`endif

// *** design/setws_pkg.sv ***
// setws_pkg: types and the slave address builder shared by both ends.
// assumes nothing beyond a SystemVerilog compiler.
package setws_pkg;
  typedef logic [7:0] setws_byte_t;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RX   = 5'h02,
    D_ACK  = 5'h04,
    D_TX   = 5'h08,
    D_RACK = 5'h10
  } setws_dst_t;

  typedef enum logic [2:0] {
    K_SLAVE = 3'h1,
    K_WORD  = 3'h2,
    K_DATA  = 3'h4
  } setws_kind_t;

  typedef enum logic [8:0] {
    H_IDLE   = 9'h001,
    H_START  = 9'h002,
    H_SADDR  = 9'h004,
    H_WADDR  = 9'h008,
    H_WDATA  = 9'h010,
    H_RSTART = 9'h020,
    H_RADDR  = 9'h040,
    H_RDATA  = 9'h080,
    H_STOP   = 9'h100
  } setws_hst_t;

  function automatic setws_byte_t setws_slave_addr(input logic [3:0] id,
                                                   input logic       sel,
                                                   input logic [1:0] hi,
                                                   input logic       rd);
    return {id, sel, hi, rd};
  endfunction : setws_slave_addr
endpackage : setws_pkg

// *** design/setws_link_if.sv ***
// setws_link_if: the two-wire link between the bus master and the memory.
// assumes a pull-up on the data line; the clock is driven by the master only.
`timescale 1ns/1ps
`default_nettype none
interface setws_link_if;
  logic scl;
  logic host_sda_oe;
  logic host_sda_out;
  logic dev_sda_oe;
  logic dev_sda_out;
  logic sda;

  // open drain: a released line reads high
  assign sda = (~host_sda_oe | host_sda_out) & (~dev_sda_oe | dev_sda_out);

  modport host (output scl, output host_sda_oe, output host_sda_out, input sda);
  modport dev  (input scl, input sda, output dev_sda_oe, output dev_sda_out);
endinterface : setws_link_if
`default_nettype wire

// *** design/setws_fifo.sv ***
// setws_fifo: small valid/ready FIFO for bytes waiting to go on the link.
// assumes a single clock domain; DEPTH must be a power of two.
`timescale 1ns/1ps
`default_nettype none
`include "setws_defs.svh"
module setws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SETWS_FIFO_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wp_ff;
  logic [AW:0]      rp_ff;
  logic             push;
  logic             pop;

  // pointers carry one extra wrap bit so full and empty stay distinct
  assign in_ready_o  = {~wp_ff[AW], wp_ff[AW-1:0]} != rp_ff;
  assign out_valid_o = wp_ff != rp_ff;
  assign out_data_o  = mem_ff[rp_ff[AW-1:0]];
  assign push        = in_valid_i & in_ready_o & ce_i;
  assign pop         = out_valid_o & out_ready_i & ce_i;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop) rp_ff <= rp_ff + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) mem_ff[wp_ff[AW-1:0]] <= in_data_i;
  end
endmodule : setws_fifo
`default_nettype wire

// *** design/setws_host.sv ***
// setws_host: two-wire bus master; makes the serial clock by dividing clock_i.
// assumes the memory end on the same link; write data arrives via the FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "setws_defs.svh"
module setws_host #(
  parameter int         QTR_CYC = `SETWS_SCL_QTR_CYC,
  parameter int         DEPTH   = `SETWS_FIFO_DEPTH,
  parameter logic [3:0] TYPE_ID = `SETWS_TYPE_ID
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   ce_i,
  input  wire logic                   cmd_valid_i,
  output logic                        cmd_ready_o,
  input  wire logic                   cmd_read_i,
  input  wire logic                   cmd_cur_i,
  input  wire logic                   cmd_sel_i,
  input  wire logic [9:0]             cmd_addr_i,
  input  wire logic [3:0]             cmd_len_i,
  input  wire logic                   wr_valid_i,
  output logic                        wr_ready_o,
  input  wire setws_pkg::setws_byte_t wr_data_i,
  output logic                        rd_valid_o,
  output var setws_pkg::setws_byte_t  rd_data_o,
  output logic                        done_o,
  output logic                        nack_o,
  setws_link_if.host                  link
);
  import setws_pkg::*;
  localparam int DW = $clog2(QTR_CYC + 1);

  setws_hst_t    st_ff;
  setws_hst_t    nxt_st;
  logic [DW-1:0] div_ff;
  logic [1:0]    qt_ff;
  logic [3:0]    bit_ff;
  logic [3:0]    cnt_ff;
  logic [3:0]    len_ff;
  logic [1:0]    sda_sy_ff;
  setws_byte_t   tx_ff;
  setws_byte_t   rx_ff;
  setws_byte_t   f_data;
  logic [9:0]    addr_ff;
  logic          oe_ff;
  logic          ack_ff;
  logic          nack_ff;
  logic          rd_ff;
  logic          cur_ff;
  logic          sel_ff;
  logic          f_valid;
  logic          f_pop;
  logic          is_tx;
  logic          is_byte;
  logic          is_st;
  logic          last_bit;
  logic          stall;
  logic          tick;
  logic          el_end;

  setws_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_data_i),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_data)
  );

  // ==========================================================
  // bit engine: four quarters per clock period
  assign is_tx    = st_ff inside {H_SADDR, H_WADDR, H_WDATA, H_RADDR};
  assign is_byte  = is_tx | (st_ff == H_RDATA);
  assign is_st    = (st_ff == H_START) | (st_ff == H_RSTART);
  assign last_bit = ~is_byte | (bit_ff == 4'h8);
  // empty FIFO stretches the clock high after the ack instead of losing data
  assign stall    = (qt_ff == 2'h3) & last_bit & (nxt_st == H_WDATA) & ~f_valid;
  // gated so a frozen divider cannot stretch the one-cycle pulses
  assign tick     = ce_i & (st_ff != H_IDLE) & ~stall & (div_ff == DW'(QTR_CYC - 1));
  assign el_end   = tick & (qt_ff == 2'h3) & last_bit;
  assign f_pop    = el_end & (nxt_st == H_WDATA);

  // clock stays high into a first start: no stray clock edge before it
  assign link.scl          = (st_ff == H_IDLE) | (st_ff == H_START) | qt_ff[1]; // see [RULE_01]
  assign link.host_sda_oe  = oe_ff;
  assign link.host_sda_out = 1'b0;
  assign cmd_ready_o       = st_ff == H_IDLE;
  assign rd_valid_o        = el_end & (st_ff == H_RDATA);
  assign rd_data_o         = rx_ff;
  assign done_o            = el_end & (st_ff == H_STOP);
  assign nack_o            = nack_ff;

  always_comb begin
    case (st_ff)
      H_START:  nxt_st = H_SADDR;
      H_SADDR:  nxt_st = !ack_ff ? H_STOP : (rd_ff && cur_ff) ? H_RDATA : H_WADDR;
      H_WADDR:  nxt_st = !ack_ff ? H_STOP : rd_ff ? H_RSTART : H_WDATA; // see [RULE_22]
      H_WDATA:  nxt_st = (!ack_ff || cnt_ff == len_ff) ? H_STOP : H_WDATA; // see [RULE_16]
      H_RSTART: nxt_st = H_RADDR;
      H_RADDR:  nxt_st = !ack_ff ? H_STOP : H_RDATA;
      H_RDATA:  nxt_st = (cnt_ff == len_ff) ? H_STOP : H_RDATA; // see [RULE_10]
      H_STOP:   nxt_st = H_IDLE;
      default:  nxt_st = H_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) sda_sy_ff <= 2'h3;
    else if (ce_i) sda_sy_ff <= {sda_sy_ff[0], link.sda};
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_ff <= '0;
      qt_ff  <= 2'h0;
    end else if (ce_i) begin
      if (st_ff == H_IDLE || tick) div_ff <= '0;
      else if (!stall) div_ff <= div_ff + 1'b1;
      if (st_ff == H_IDLE) qt_ff <= 2'h0;
      else if (tick) qt_ff <= qt_ff + 2'h1;
    end
  end

  // ==========================================================
  // data line: change only with the clock low, except start and stop
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) oe_ff <= 1'b0;
    else if (ce_i && tick && qt_ff == 2'h0) begin // see [RULE_05]
      if (is_st) oe_ff <= 1'b0;
      else if (st_ff == H_STOP) oe_ff <= 1'b1;
      else if (bit_ff != 4'h8) oe_ff <= is_tx & ~tx_ff[7];
      else oe_ff <= ~is_tx & (cnt_ff != len_ff); // see [RULE_06] [RULE_19]
    end else if (ce_i && tick && qt_ff == 2'h2) begin
      if (is_st) oe_ff <= 1'b1; // see [RULE_01]
      else if (st_ff == H_STOP) oe_ff <= 1'b0; // see [RULE_03]
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_ff  <= 8'h00;
      ack_ff <= 1'b0;
    end else if (ce_i && tick && qt_ff == 2'h2 && is_byte) begin
      if (bit_ff != 4'h8 && !is_tx) rx_ff <= {rx_ff[6:0], sda_sy_ff[1]};
      if (bit_ff == 4'h8) ack_ff <= ~sda_sy_ff[1];
    end
  end

  // ==========================================================
  // command sequencer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff   <= H_IDLE;
      bit_ff  <= 4'h0;
      cnt_ff  <= 4'h0;
      len_ff  <= 4'h0;
      tx_ff   <= 8'h00;
      addr_ff <= 10'h000;
      nack_ff <= 1'b0;
      rd_ff   <= 1'b0;
      cur_ff  <= 1'b0;
      sel_ff  <= 1'b0;
    end else if (ce_i) begin
      if (st_ff == H_IDLE && cmd_valid_i) begin
        st_ff   <= H_START;
        bit_ff  <= 4'h0;
        cnt_ff  <= 4'h0;
        len_ff  <= cmd_len_i;
        addr_ff <= cmd_addr_i;
        rd_ff   <= cmd_read_i;
        cur_ff  <= cmd_cur_i;
        sel_ff  <= cmd_sel_i;
        nack_ff <= 1'b0;
      end else if (el_end) begin
        st_ff  <= nxt_st;
        bit_ff <= 4'h0;
        if (st_ff == H_WDATA || st_ff == H_RDATA) cnt_ff <= cnt_ff + 4'h1;
        // a refused address byte is how acknowledge polling sees a busy memory
        if (is_tx && !ack_ff) nack_ff <= 1'b1; // see [RULE_18]
        case (nxt_st)
          H_SADDR: tx_ff <= setws_slave_addr(TYPE_ID, sel_ff, addr_ff[9:8],
                                             rd_ff & cur_ff); // see [RULE_13]
          H_WADDR: tx_ff <= addr_ff[7:0];
          H_WDATA: tx_ff <= f_data;
          H_RADDR: tx_ff <= setws_slave_addr(TYPE_ID, sel_ff, addr_ff[9:8], 1'b1);
          default: tx_ff <= tx_ff;
        endcase
      end else if (tick && qt_ff == 2'h3 && is_byte) begin
        bit_ff <= bit_ff + 4'h1;
        if (is_tx) tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end
endmodule : setws_host
`default_nettype wire

// *** tb/setws_link_checker.sv ***
// setws_link_checker: timing checks on the two-wire link between both ends.
// assumes it sits beside the link interface in the bench, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module setws_link_checker (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic busy_o,
  input wire logic standby_o
);
  logic [3:0] bit_ff;
  logic       scl_ff;
  // ==========================================
  // clock rises since the last start, F when idle; saturates at E
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) scl_ff <= 1'b1;
    else scl_ff <= scl;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) bit_ff <= 4'hF;
    else if (scl && $fell(sda)) bit_ff <= 4'h0;
    else if (scl && $rose(sda)) bit_ff <= 4'hF;
    else if (scl && !scl_ff && bit_ff < 4'hE) bit_ff <= bit_ff + 4'h1;
  end
  // ==========================================
  // properties
  sequence start_s; scl && $fell(sda); endsequence
  sequence stop_s; scl && $rose(sda); endsequence
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  host_edge_kind_a: assert property (scl && $past(scl) && $changed(host_sda_oe) |->
    (host_sda_oe && $fell(sda)) || (!host_sda_oe && $rose(sda)))
    else $error("host data moved while clock high outside start or stop");
  busy_quiet_a: assert property (busy_o |-> !dev_sda_oe)
    else $error("device drove data while busy");
  stop_standby_a: assert property (stop_s |-> ##[1:6] (standby_o || busy_o))
    else $error("no standby after stop");
  start_wake_a: assert property (start_s ##0 !busy_o |-> ##[1:6] !standby_o)
    else $error("start not taken");
  // the ninth rise shows a cycle before the count moves; the ack is legal there
  addr_quiet_a: assert property (bit_ff < 4'h8 ||
    (bit_ff == 4'h8 && scl && scl_ff) |-> !dev_sda_oe)
    else $error("device drove data during slave address");
  addr_release_a: assert property (bit_ff == 4'h9 && scl && scl_ff |-> !host_sda_oe)
    else $error("host held data in ninth clock");
  first_low_a: assert property ($fell(scl) |-> bit_ff != 4'hF)
    else $error("clock toggled without a start");
endmodule : setws_link_checker
`default_nettype wire

// *** tb/serial_eeprom_two_wire_slave_tb.sv ***
// serial_eeprom_two_wire_slave_tb: host and memory ends joined on one link.
// assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_two_wire_slave_tb;
  import setws_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cmd_valid = 1'b0, cmd_read = 1'b0, cmd_cur = 1'b0, cmd_sel = 1'b0;
  logic [9:0]  cmd_addr = 10'h000;
  logic [3:0]  cmd_len = 4'h0;
  logic        wr_valid = 1'b0, ce = 1'b1;
  setws_byte_t wr_data = 8'h00;
  logic        sel_pin;
  logic        cmd_ready, wr_ready, rd_valid, done, nack, busy, standby;
  setws_byte_t rd_data;
  setws_byte_t mem [1024];
  setws_byte_t got [$];
  int          seed = 32'hCEA6;
  int          n_mismatch = 0;
  int          compares = 0;
  always #12.5 clock_i = ~clock_i;
  // ==========================================
  // both ends; short link clock and write cycle to keep the run brief
  setws_link_if link ();
  setws_host #(.QTR_CYC(8)) i_setws_host (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
    .cmd_cur_i(cmd_cur), .cmd_sel_i(cmd_sel), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len),
    .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_data), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done), .nack_o(nack), .link(link));
  setws_dev #(.WRITE_CYCLES(2000)) i_setws_dev (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .ce_i(ce), .device_select_pin_i(sel_pin), .link(link), .busy_o(busy),
    .standby_o(standby), .rx_byte_o());
  setws_link_checker i_setws_link_checker (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .scl(link.scl), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .busy_o(busy), .standby_o(standby));
  // ==========================================
  // tasks
  function automatic logic [9:0] in_page(input logic [9:0] a, input int k);
    return {a[9:4], 4'(a[3:0] + 4'(k))};
  endfunction : in_page
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // valid stays up after a push; the caller drops it
  task automatic put(input logic [9:0] a);
    mem[a] = 8'($random(seed));
    wr_valid = 1'b1;
    wr_data = mem[a];
    while (wr_ready !== 1'b1) @(posedge clock_i) #1;
    @(posedge clock_i) #1;
  endtask : put
  task automatic run(input logic rd, input logic cur, input logic [9:0] a, input logic [3:0] n);
    got.delete();
    while (cmd_ready !== 1'b1) @(posedge clock_i) #1;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_cur = cur;
    cmd_addr = a;
    cmd_len = n;
    @(posedge clock_i) #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
      @(posedge clock_i) #1;
    end
    @(posedge clock_i) #1;
  endtask : run
  task automatic expect_got(input logic [9:0] a, input int n);
    chk(8'(got.size()), 8'(n));
    for (int i = 0; i < got.size(); i++) chk(got[i], mem[10'(a + 10'(i))]);
  endtask : expect_got
  // ==========================================
  // main sequence
  initial begin : main
    logic [9:0] base;
    int         k;
    sel_pin = 1'($random(seed));
    cmd_sel = sel_pin;
    repeat (2) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    chk({6'h00, standby, busy}, 8'h02);
    cmd_sel = ~sel_pin;
    run(1'b1, 1'b1, 10'h000, 4'h0);
    chk({7'h00, nack}, 8'h01);
    cmd_sel = sel_pin;
    base = (10'($random(seed)) & 10'h1E0) | 10'h010;
    for (k = 0; k < 8; k++) put(in_page(base | 10'h00C, k));
    wr_valid = 1'b0;
    chk({7'h00, wr_ready}, 8'h00);
    fork
      run(1'b0, 1'b0, base | 10'h00C, 4'hF);
      begin
        for (int j = 8; j < 16; j++) put(in_page(base | 10'h00C, j));
        wr_valid = 1'b0;
      end
    join
    chk({6'h00, nack, busy}, 8'h01);
    k = 0;
    do begin
      run(1'b1, 1'b1, base, 4'h0);
      k++;
    end while (nack === 1'b1 && k < 40);
    chk(8'(k > 1), 8'h01);
    chk({7'h00, nack}, 8'h00);
    fork
      run(1'b1, 1'b0, base, 4'hF);
      begin
        // freeze both ends mid-read; no byte may be lost or repeated
        repeat (1500) @(posedge clock_i);
        #1 ce = 1'b0;
        repeat (40) @(posedge clock_i);
        #1 ce = 1'b1;
      end
    join
    expect_got(base, 16);
    put(10'h3FE);
    put(10'h3FF);
    wr_valid = 1'b0;
    run(1'b0, 1'b0, 10'h3FE, 4'h1);
    while (busy === 1'b1) @(posedge clock_i) #1;
    put(10'h000);
    put(10'h001);
    wr_valid = 1'b0;
    run(1'b0, 1'b0, 10'h000, 4'h1);
    while (busy === 1'b1) @(posedge clock_i) #1;
    run(1'b1, 1'b0, 10'h3FF, 4'h1);
    expect_got(10'h3FF, 2);
    run(1'b1, 1'b1, 10'h000, 4'h0);
    expect_got(10'h001, 1);
    final_report();
  end
  initial begin : watchdog
    repeat (100000) @(posedge clock_i);
    n_mismatch++;
    final_report();
  end
endmodule : serial_eeprom_two_wire_slave_tb
`default_nettype wire
